// ### logic/flow_ctl_pkg.sv
package flow_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // Printed offset is not a multiple of four: it is kept as an index
  localparam logic [15:0] FLOW_CONFIG_IDX = 16'hffa3;
  localparam logic [17:0] FLOW_CONFIG_ADDR = {FLOW_CONFIG_IDX, 2'b00};
  localparam logic [15:0] MODEM_CTL_IDX = 16'hffa4;
  localparam logic [17:0] MODEM_CTL_ADDR = {MODEM_CTL_IDX, 2'b00};
  localparam logic [17:0] FLOW_STATUS_ADDR = 18'h3fe00;
  localparam logic [7:0] FLOW_CONFIG_RST = 8'h00;
  localparam logic [7:0] MODEM_CTL_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TX_SOFT_FLOW_EN_BIT = 0;
  localparam int TX_RESUME_ON_ANY_EN_BIT = 1;
  localparam int CTS_GATE_EN_BIT = 2;
  localparam int DSR_GATE_EN_BIT = 3;
  localparam int RX_SOFT_FLOW_MATCH_EN_BIT = 4;
  localparam int RTS_FLOW_EN_BIT = 5;
  localparam int DTR_FLOW_EN_BIT = 6;
  localparam int HALF_DUPLEX_BUS_EN_BIT = 7;
  localparam int MC_RX_ALWAYS_ON_BIT = 1;
  localparam int MC_DTR_BIT = 4;
  localparam int MC_RTS_BIT = 5;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int LEAD_BIT_TIMES = 2;
  localparam logic [15:0] BIT_DIV_RST = 16'h0010;

  typedef enum logic [2:0] {
    DIR_IDLE = 3'b001,
    DIR_LEAD = 3'b010,
    DIR_SEND = 3'b100
  } dir_state_t;

endpackage : flow_ctl_pkg

// ### logic/bit_tick_gen.sv
module bit_tick_gen
  import flow_ctl_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic restart,
  input wire logic [DIV_W-1:0] divisor,
  // Enable pulse, one per bit time
  output logic bit_tick
);
  import flow_ctl_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } gen_state_t;

  gen_state_t st_r;
  gen_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt + 1'b1 >= divisor)
    begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bit_tick = st_r.tick;

endmodule : bit_tick_gen

// ### logic/uart_flow_control.sv
// Contract
// RQ1: Config register at index ffa3, eight bits read/write, resets to zero.
// RQ2: Bit 0 enables transmitter Xon/Xoff flow control.
// RQ3: Bit 1 enables transmitter Xon-on-any/Xoff flow control.
// RQ4: Bit 2 set: clear-to-send high halts transmitter, low resumes.
// RQ5: Bit 3 set: data-set-ready high halts transmitter, low resumes.
// RQ6: Loopback software must set a gate enable bit for hardware gating.
// RQ7: Bit 4 enables receiver matching against Xon and Xoff characters.
// RQ8: Bit 5: request-to-send high at halt level, low at resume level.
// RQ9: Bit 6: terminal-ready high at halt level, low at resume level.
// RQ10: Bit 7 selects half-duplex bus mode; clear is full duplex.
// RQ11: Bus mode: outputs always opposite; idle request low, ready high.
// RQ12: Bus mode: request high, ready low two bit times before first bit.
// RQ13: Bus mode: after transmission finishes shifting, request low, ready high.
// RQ14: Bus mode ignores manual request and ready modem-control bits.
// RQ15: Both software flow bits written set: both are cleared.
// RQ16: Combined flow: stop on either halt; resume needs both cleared.
// RQ17: Reset leaves transmitter in Xon state, all flow control off.
// RQ18: Bus mode, receiver disabled while request high unless always-on set.
// RQ19: Resume-on-any mode: Xoff halts, any later character resumes.
// RQ20: Halting only takes effect at a character boundary.
//
// Local design decision: the APB register port.
module uart_flow_control
  import flow_ctl_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic uart_soft_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bit time and characters
  input wire logic [DIV_W-1:0] bit_divisor,
  input wire logic [7:0] xon_char,
  input wire logic [7:0] xoff_char,
  // Receiver side
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_fifo_halt_level,
  input wire logic rx_fifo_resume_level,
  output logic rx_enable,
  output logic rx_xon_seen,
  output logic rx_xoff_seen,
  // Transmitter side
  input wire logic tx_pending,
  input wire logic tx_char_start,
  input wire logic tx_shift_busy,
  output logic tx_allowed,
  // Modem pins
  input wire logic cts_in,
  input wire logic dsr_in,
  output logic rts_out,
  output logic dtr_out
);
  import flow_ctl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] mc;
    logic soft_xoff;
    logic tx_stopped;
    logic rx_halted;
    dir_state_t dir;
    logic [1:0] lead_cnt;
    logic rts;
    logic dtr;
    logic xon_seen;
    logic xoff_seen;
    logic [31:0] rdata;
  } fc_state_t;

  fc_state_t st_r;
  fc_state_t st_nxt;
  logic bit_tick;
  logic wr_en;
  logic rd_en;
  logic hw_halt;
  logic want_stop;
  logic rx_match;
  logic [7:0] wbyte;

  function automatic logic [7:0] legal_cfg(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[TX_SOFT_FLOW_EN_BIT] && v[TX_RESUME_ON_ANY_EN_BIT])
    begin
      r[TX_SOFT_FLOW_EN_BIT] = 1'b0;
      r[TX_RESUME_ON_ANY_EN_BIT] = 1'b0;
    end
    return r;
  endfunction : legal_cfg

  bit_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(st_r.dir == DIR_IDLE),
    .divisor(bit_divisor),
    .bit_tick(bit_tick)
  );

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  // ----------------------------------------------------------------------
  // Flow decisions
  // ----------------------------------------------------------------------
  always_comb
  begin
    hw_halt = (st_r.cfg[CTS_GATE_EN_BIT] && cts_in)      // [RQ4] [RQ6]
            || (st_r.cfg[DSR_GATE_EN_BIT] && dsr_in);     // [RQ5]
    want_stop = hw_halt || st_r.soft_xoff;               // [RQ16]
    rx_match = rx_char_valid && st_r.cfg[RX_SOFT_FLOW_MATCH_EN_BIT]; // [RQ7]
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.xon_seen = 1'b0;
    st_nxt.xoff_seen = 1'b0;
    if (rd_en)
    begin
      if (paddr[17:0] == FLOW_CONFIG_ADDR)
      begin
        st_nxt.rdata = {24'h000000, st_r.cfg};
      end
      else if (paddr[17:0] == MODEM_CTL_ADDR)
      begin
        st_nxt.rdata = {24'h000000, st_r.mc};
      end
      else if (paddr[17:0] == FLOW_STATUS_ADDR)
      begin
        st_nxt.rdata = {27'h0000000, st_r.rx_halted, st_r.soft_xoff, st_r.tx_stopped, st_r.rts, st_r.dtr};
      end
      else
      begin
        st_nxt.rdata = 32'h00000000;
      end
    end
    if (wr_en)
    begin
      if (paddr[17:0] == FLOW_CONFIG_ADDR)
      begin
        st_nxt.cfg = legal_cfg(wbyte);                   // [RQ1] [RQ2] [RQ3] [RQ15]
      end
      else if (paddr[17:0] == MODEM_CTL_ADDR)
      begin
        st_nxt.mc = wbyte;
      end
    end
    // Software flow: Xoff stops, Xon (or any other char in resume-on-any) restarts
    if (!(st_r.cfg[TX_SOFT_FLOW_EN_BIT] || st_r.cfg[TX_RESUME_ON_ANY_EN_BIT]))
    begin
      st_nxt.soft_xoff = 1'b0;
    end
    else if (rx_char_valid)
    begin
      if (rx_char == xoff_char)
      begin
        st_nxt.soft_xoff = 1'b1;                         // [RQ2] [RQ19]
      end
      else if (st_r.cfg[TX_RESUME_ON_ANY_EN_BIT] || rx_char == xon_char)
      begin
        st_nxt.soft_xoff = 1'b0;                         // [RQ3] [RQ19]
      end
    end
    if (rx_match)
    begin
      st_nxt.xon_seen = (rx_char == xon_char);
      st_nxt.xoff_seen = (rx_char == xoff_char);
    end
    // The stop flag only moves while no character is on the wire
    if (!tx_shift_busy && !tx_char_start)
    begin
      st_nxt.tx_stopped = want_stop;                     // [RQ20] [RQ16]
    end
    if (rx_fifo_halt_level)
    begin
      st_nxt.rx_halted = 1'b1;
    end
    else if (rx_fifo_resume_level)
    begin
      st_nxt.rx_halted = 1'b0;
    end
    // Direction sequencer for the half-duplex bus
    case (st_r.dir)
      DIR_IDLE:
      begin
        st_nxt.lead_cnt = 2'd0;
        if (st_r.cfg[HALF_DUPLEX_BUS_EN_BIT] && tx_pending)
        begin
          st_nxt.dir = DIR_LEAD;                         // [RQ12]
        end
      end
      DIR_LEAD:
      begin
        if (!st_r.cfg[HALF_DUPLEX_BUS_EN_BIT])
        begin
          st_nxt.dir = DIR_IDLE;
        end
        else if (bit_tick)
        begin
          if (st_r.lead_cnt == 2'(LEAD_BIT_TIMES - 1))
          begin
            st_nxt.dir = DIR_SEND;                       // [RQ12]
          end
          st_nxt.lead_cnt = st_r.lead_cnt + 2'd1;
        end
      end
      DIR_SEND:
      begin
        if (!st_r.cfg[HALF_DUPLEX_BUS_EN_BIT]
            || (!tx_pending && !tx_shift_busy && !tx_char_start))
        begin
          st_nxt.dir = DIR_IDLE;                         // [RQ13]
        end
      end
      default:
      begin
        st_nxt.dir = DIR_IDLE;
      end
    endcase
    // Pin levels
    if (st_nxt.cfg[HALF_DUPLEX_BUS_EN_BIT])
    begin
      st_nxt.rts = (st_nxt.dir != DIR_IDLE);             // [RQ10] [RQ14]
      st_nxt.dtr = !(st_nxt.dir != DIR_IDLE);            // [RQ11]
    end
    else
    begin
      st_nxt.rts = st_nxt.cfg[RTS_FLOW_EN_BIT] ? st_nxt.rx_halted : st_nxt.mc[MC_RTS_BIT]; // [RQ8]
      st_nxt.dtr = st_nxt.cfg[DTR_FLOW_EN_BIT] ? st_nxt.rx_halted : st_nxt.mc[MC_DTR_BIT]; // [RQ9]
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '{cfg: FLOW_CONFIG_RST, mc: MODEM_CTL_RST, soft_xoff: 1'b0, tx_stopped: 1'b0,
                rx_halted: 1'b0, dir: DIR_IDLE, lead_cnt: 2'd0, rts: 1'b0, dtr: 1'b0,
                xon_seen: 1'b0, xoff_seen: 1'b0, rdata: 32'h00000000};  // [RQ1] [RQ17]
    end
    else if (uart_soft_rst)
    begin
      st_r <= '{cfg: FLOW_CONFIG_RST, mc: MODEM_CTL_RST, soft_xoff: 1'b0, tx_stopped: 1'b0,
                rx_halted: 1'b0, dir: DIR_IDLE, lead_cnt: 2'd0, rts: 1'b0, dtr: 1'b0,
                xon_seen: 1'b0, xoff_seen: 1'b0, rdata: 32'h00000000};  // [RQ17]
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Read data is captured in setup, so the access phase of every transfer lasts one cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_r.rdata;
  assign rts_out = st_r.rts;
  assign dtr_out = st_r.dtr;
  assign rx_xon_seen = st_r.xon_seen;
  assign rx_xoff_seen = st_r.xoff_seen;
  assign tx_allowed = !st_r.tx_stopped
                      && (!st_r.cfg[HALF_DUPLEX_BUS_EN_BIT] || st_r.dir == DIR_SEND);
  assign rx_enable = !(st_r.cfg[HALF_DUPLEX_BUS_EN_BIT] && st_r.rts
                       && !st_r.mc[MC_RX_ALWAYS_ON_BIT]); // [RQ18]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_cfg_illegal: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(st_r.cfg[0] && st_r.cfg[1])) else $error("both soft flow bits set"); // [RQ15]
  a_cts_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.cfg[2] && cts_in && !tx_shift_busy && !tx_char_start && !uart_soft_rst && $stable(st_r.cfg))
    |=> !tx_allowed) else $error("cts did not halt"); // [RQ4]
  a_dsr_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.cfg[3] && dsr_in && !tx_shift_busy && !tx_char_start && !uart_soft_rst && $stable(st_r.cfg))
    |=> !tx_allowed) else $error("dsr did not halt"); // [RQ5]
  a_bus_opposite: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_r.cfg[7] |-> (rts_out != dtr_out)) else $error("bus pins not opposite"); // [RQ11]
  a_boundary_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tx_shift_busy && !uart_soft_rst) |=> $stable(st_r.tx_stopped)) else $error("halt mid character"); // [RQ20]
  a_rts_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.cfg[5] && !st_r.cfg[7] && rx_fifo_halt_level && !wr_en && !uart_soft_rst) |=> rts_out)
    else $error("rts not raised at halt level"); // [RQ8]
  a_dtr_resume: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.cfg[6] && !st_r.cfg[7] && !rx_fifo_halt_level && rx_fifo_resume_level && !wr_en
     && !uart_soft_rst) |=> !dtr_out) else $error("dtr not dropped at resume"); // [RQ9]
  a_rx_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.cfg[7] && rts_out && !st_r.mc[1]) |-> !rx_enable) else $error("receiver not gated"); // [RQ18]
  a_lead_time: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.dir == DIR_IDLE && st_nxt.dir == DIR_LEAD) |=> !tx_allowed [*2]) else $error("sent without lead"); // [RQ12]
  a_reset_xon: assert property (@(posedge sys_clk) disable iff (!nrst)
    uart_soft_rst |=> (st_r.cfg == 8'h00 && !st_r.soft_xoff)) else $error("soft reset state wrong"); // [RQ17]

endmodule : uart_flow_control

// ### verif/modem_partner.sv
// ----------------------------------------------------------------------
// Far-end modem lines and bus transceiver
// ----------------------------------------------------------------------
module modem_partner
(
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic cts_req,
  input wire logic dsr_req,
  // Pins
  input wire logic rts_out,
  input wire logic dtr_out,
  output logic cts_in,
  output logic dsr_in,
  output logic bus_driving
);
  timeunit 1ns;
  timeprecision 1ps;
  // Modem lines move a cycle after the request, like a real remote end
  always @(posedge sys_clk)
  begin
    cts_in <= cts_req;
    dsr_in <= dsr_req;
  end
  // Transceiver drives the bus only with the driver enabled and receiver off
  assign bus_driving = rts_out & ~dtr_out;
endmodule : modem_partner

// ### verif/tb_top.sv
module tb_top;
  import flow_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, nrst = 0, uart_soft_rst = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr;
  logic rx_char_valid = 0, rx_fifo_halt_level = 0, rx_fifo_resume_level = 0;
  logic [7:0] rx_char = '0;
  logic rx_enable, rx_xon_seen, rx_xoff_seen;
  logic [1:0] seen_pair = '0;
  logic tx_pending = 0, tx_char_start = 0, tx_shift_busy = 0, tx_allowed;
  logic cts_in, dsr_in, rts_out, dtr_out, cts_req = 0, dsr_req = 0, bus_driving;
  int err_total = 0, total_checks = 0;
  localparam logic [31:0] CFG = {14'h0, FLOW_CONFIG_ADDR};
  localparam logic [31:0] MC = {14'h0, MODEM_CTL_ADDR};

  always #5 sys_clk = ~sys_clk;

  uart_flow_control #(.DIV_W(16)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .uart_soft_rst(uart_soft_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_divisor(16'h0004), .xon_char(8'h11), .xoff_char(8'h13),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_fifo_halt_level(rx_fifo_halt_level),
    .rx_fifo_resume_level(rx_fifo_resume_level), .rx_enable(rx_enable), .rx_xon_seen(rx_xon_seen),
    .rx_xoff_seen(rx_xoff_seen), .tx_pending(tx_pending), .tx_char_start(tx_char_start),
    .tx_shift_busy(tx_shift_busy), .tx_allowed(tx_allowed), .cts_in(cts_in), .dsr_in(dsr_in),
    .rts_out(rts_out), .dtr_out(dtr_out));
  modem_partner u_far (.sys_clk(sys_clk), .cts_req(cts_req), .dsr_req(dsr_req), .rts_out(rts_out),
    .dtr_out(dtr_out), .cts_in(cts_in), .dsr_in(dsr_in), .bus_driving(bus_driving));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Settle first so outputs are read away from the launching edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send_rx(input logic [7:0] c);
    @(posedge sys_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    // Match pulses stand for the one cycle after the character is taken
    @(negedge sys_clk);
    seen_pair = {rx_xon_seen, rx_xoff_seen};
    cyc(3);
  endtask : send_rx

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    apb(0, CFG, 0); chk("cfg_rst", rd, 32'h0);
    chk("slverr", pslverr, 0);
    apb(1, CFG, 8'hfc); apb(0, CFG, 0); chk("cfg_rw", rd, 32'hfc);
    apb(1, CFG, 8'h0b); apb(0, CFG, 0); chk("cfg_both_soft", rd, 32'h08);
    apb(0, 32'h0000_0100, 0); chk("unmapped", rd, 32'h0);
    @(posedge sys_clk) uart_soft_rst <= 1'b1;
    @(posedge sys_clk) uart_soft_rst <= 1'b0;
    apb(0, CFG, 0); chk("cfg_soft_rst", rd, 32'h0);
  endtask : t_regs

  task automatic t_hw_gate();
    for (int i = 0; i < 2; i++)
    begin
      apb(1, CFG, 8'h00);
      @(posedge sys_clk) {dsr_req, cts_req} <= 2'b01 << i;
      cyc(4); chk("gate_off", tx_allowed, 1);
      // Loopback users need the enable bit for any hardware gating
      apb(1, CFG, 8'h04 << i);
      cyc(3); chk("gate_halt", tx_allowed, 0);
      @(posedge sys_clk) {dsr_req, cts_req} <= 2'b00;
      cyc(4); chk("gate_go", tx_allowed, 1);
      @(posedge sys_clk) tx_shift_busy <= 1'b1;
      @(posedge sys_clk) {dsr_req, cts_req} <= 2'b01 << i;
      cyc(5); chk("gate_mid_char", tx_allowed, 1);
      @(posedge sys_clk) tx_shift_busy <= 1'b0;
      cyc(3); chk("gate_boundary", tx_allowed, 0);
      @(posedge sys_clk) {dsr_req, cts_req} <= 2'b00;
      cyc(4);
    end
  endtask : t_hw_gate

  task automatic t_soft();
    apb(1, CFG, 8'h11);
    send_rx(8'h13); chk("xoff_halt", tx_allowed, 0);
    chk("xoff_seen", seen_pair, 2'b01);
    send_rx(8'h41); chk("other_no_go", tx_allowed, 0);
    chk("other_seen", seen_pair, 2'b00);
    send_rx(8'h11); chk("xon_go", tx_allowed, 1);
    chk("xon_seen", seen_pair, 2'b10);
    apb(1, CFG, 8'h15);
    send_rx(8'h13); @(posedge sys_clk) cts_req <= 1'b1;
    send_rx(8'h11); chk("comb_cts_hold", tx_allowed, 0);
    @(posedge sys_clk) cts_req <= 1'b0;
    cyc(4); chk("comb_go", tx_allowed, 1);
    apb(1, CFG, 8'h12);
    send_rx(8'h13); chk("any_halt", tx_allowed, 0);
    send_rx(8'h41); chk("any_go", tx_allowed, 1);
    apb(1, CFG, 8'h01);
    send_rx(8'h13);
    chk("no_match", seen_pair, 2'b00);
    chk("xoff_no_match_halt", tx_allowed, 0);
  endtask : t_soft

  task automatic t_rx_flow();
    apb(1, CFG, 8'h60);
    @(posedge sys_clk) rx_fifo_halt_level <= 1'b1;
    cyc(3); chk("flow_high", {rts_out, dtr_out}, 2'b11);
    apb(0, {14'h0, FLOW_STATUS_ADDR}, 0);
    chk("status_halt", rd, 32'h13);
    @(posedge sys_clk) {rx_fifo_halt_level, rx_fifo_resume_level} <= 2'b01;
    cyc(3); chk("flow_low", {rts_out, dtr_out}, 2'b00);
    @(posedge sys_clk) rx_fifo_resume_level <= 1'b0;
  endtask : t_rx_flow

  task automatic t_half();
    apb(1, MC, 8'h30);
    apb(0, MC, 0);
    chk("mc_rw", rd, 32'h30);
    apb(1, CFG, 8'h80);
    cyc(2); chk("hd_idle", {rts_out, dtr_out}, 2'b01);
    @(posedge sys_clk) tx_pending <= 1'b1;
    cyc(3); chk("hd_lead", {rts_out, dtr_out, tx_allowed}, 3'b100);
    chk("hd_rx_off", rx_enable, 0);
    cyc(9); chk("hd_ready", {tx_allowed, bus_driving}, 2'b11);
    @(posedge sys_clk) {tx_char_start, tx_shift_busy} <= 2'b11;
    @(posedge sys_clk) {tx_char_start, tx_pending} <= 2'b00;
    cyc(6); chk("hd_shift", {rts_out, dtr_out}, 2'b10);
    @(posedge sys_clk) tx_shift_busy <= 1'b0;
    cyc(3); chk("hd_done", {rts_out, dtr_out}, 2'b01);
    apb(1, MC, 8'h02);
    @(posedge sys_clk) tx_pending <= 1'b1;
    cyc(3); chk("hd_rx_on", rx_enable, 1);
    @(posedge sys_clk) tx_pending <= 1'b0;
    cyc(4);
  endtask : t_half

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_hw_gate();
    t_soft();
    t_rx_flow();
    t_half();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
endmodule : tb_top
